// ---- gpm_fail_timer.sv ----
// Persistence timer: a fault is declared once a violation has lasted the limit.
// Assumes a one-cycle tick strobe on the same clock.
module gpm_fail_timer #(
  parameter int W = 12
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         tick,
  input  wire logic         viol,
  input  wire logic [W-1:0] limit,
  output logic              fault
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;
  wire          reached = (count >= limit);

  assign next_count = !viol ? '0 : (tick && !reached) ? count + 1'b1 : count;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count <= '0;
      fault <= 1'b0;
    end else begin
      count <= next_count;
      fault <= viol && (next_count >= limit);
    end
  end

endmodule

// ---- gpm_front_end.sv ----
// Model of the measurement front end and the engine stop actuator.
// Assumes the bench changes one quantity at a time through put.
module gpm_front_end (
  input  wire logic        clk,
  input  wire logic        engine_stop,
  output logic             feeding_load,
  output logic [15:0]      gen_freq,
  output logic [15:0]      batt_volt,
  output logic [15:0]      phase_v1,
  output logic [15:0]      phase_v2,
  output logic [15:0]      phase_v3,
  output logic [15:0]      phase_i1,
  output logic [15:0]      phase_i2,
  output logic [15:0]      phase_i3,
  output logic [16:0]      active_power
);
  timeunit 1ns;
  timeprecision 100ps;
  task automatic put(input int idx, input logic [16:0] v);
    @(posedge clk);
    case (idx)
      0: gen_freq <= v[15:0];
      1: batt_volt <= v[15:0];
      2: phase_v3 <= v[15:0];
      3: phase_i1 <= v[15:0];
      4: active_power <= v;
      default: feeding_load <= v[0];
    endcase
  endtask
  // Healthy running genset, load untouched
  task automatic nominal();
    @(posedge clk);
    {gen_freq, batt_volt} <= {16'h0032, 16'h00F0};
    {phase_v1, phase_v2, phase_v3} <= {3{16'h00E6}};
    {phase_i1, phase_i2, phase_i3} <= {3{16'h0064}};
    active_power <= 17'h00064;
  endtask
  initial begin
    feeding_load = 1'b1;
    nominal();
  end
  // Stopped engine no longer feeds the load
  always @(posedge clk) begin
    if (engine_stop)
      feeding_load <= 1'b0;
  end
endmodule

// ---- gpm_monitor.sv ----
// Genset protection monitor: limit comparison, fail timers, sticky alarms.
// Assumes measurements come synchronous to clk from the measurement front end.
// ============================================================================
// How it works
// - Feeding load: under low warn limit warns, under low shutdown limit stops engine.
// - Feeding load: over high warn limit warns, over high shutdown limit stops engine.
// - Frequency fault only after the frequency fail time, 0 to 10 s, default 1.
// - Battery below 12 V warns, below 9 V shuts down by default.
// - Battery above 29 V warns, above 30 V shuts down by default.
// - Battery fault only after battery fail time, up to 10 s, default 3.
// - Phase voltage off three-phase average beyond percentage flags unbalance; zero disables.
// - Voltage unbalance action: 0 none, 1 shutdown, 2 load dump, 3 warning.
// - Current unbalance uses same check, same action code, disabled at zero.
// - Negative power beyond warning limit warns; zero warning limit disables monitoring.
// - Negative power beyond load-dump limit raises reverse-power load dump.
// - Reverse-power fault after fail time, up to 120 s, default 5.
// - Feeding load: phase current above active limit faults; zero disables.
// - Limit set select picks primary, secondary or tertiary overcurrent limit.
// - Overcurrent action 0 shuts down, 1 dumps the load.
// - Multiplier 1 to 64, default 16; larger reacts faster.
// - Frequency percentages are relative to nominal frequency, default 50 Hz.
module gpm_monitor #(
  parameter int unsigned TICK_CYC = gpm_pkg::TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        feeding_load,
  input  wire logic [15:0] gen_freq,
  input  wire logic [15:0] batt_volt,
  input  wire logic [15:0] phase_v1,
  input  wire logic [15:0] phase_v2,
  input  wire logic [15:0] phase_v3,
  input  wire logic [15:0] phase_i1,
  input  wire logic [15:0] phase_i2,
  input  wire logic [15:0] phase_i3,
  input  wire logic [16:0] active_power,
  input  wire logic [1:0]  limit_set,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  output logic             warning,
  output logic             load_dump,
  output logic             shutdown,
  output logic             engine_stop,
  output logic             irq
);

  // ==========================================================================
  // Settings registers
  // ==========================================================================
  logic [15:0] nom_freq;
  logic [7:0]  flo_warn, flo_sd, fhi_warn, fhi_sd;
  logic [15:0] blo_warn, blo_sd, bhi_warn, bhi_sd;
  logic [7:0]  freq_fail, batt_fail, rpow_fail;
  logic [6:0]  oc_mult;
  logic [7:0]  vunb_pct, iunb_pct;
  logic [1:0]  vunb_act, iunb_act;
  logic        oc_act;
  logic [15:0] rpow_warn, rpow_ld;
  logic [15:0] oc_lim1, oc_lim2, oc_lim3;
  logic [gpm_pkg::N_STATUS-1:0] status, mask;

  wire wr_nom   = reg_write && reg_addr == gpm_pkg::A_NOM_FREQ;
  wire wr_flim  = reg_write && reg_addr == gpm_pkg::A_FREQ_LIM;
  wire wr_blo   = reg_write && reg_addr == gpm_pkg::A_BATT_LO;
  wire wr_bhi   = reg_write && reg_addr == gpm_pkg::A_BATT_HI;
  wire wr_tim   = reg_write && reg_addr == gpm_pkg::A_TIMERS;
  wire wr_unb   = reg_write && reg_addr == gpm_pkg::A_UNBAL;
  wire wr_rpow  = reg_write && reg_addr == gpm_pkg::A_RPOW;
  wire wr_oc12  = reg_write && reg_addr == gpm_pkg::A_OC_LIM12;
  wire wr_oc3   = reg_write && reg_addr == gpm_pkg::A_OC_LIM3;
  wire wr_stat  = reg_write && reg_addr == gpm_pkg::A_STATUS;
  wire wr_mask  = reg_write && reg_addr == gpm_pkg::A_MASK;

  // Out-of-range timer values clamp to the ceilings
  wire [7:0] w_ff = (reg_wdata[7:0] > gpm_pkg::FB_SEC_MAX) ? gpm_pkg::FB_SEC_MAX
                                                            : reg_wdata[7:0];
  wire [7:0] w_bf = (reg_wdata[15:8] > gpm_pkg::FB_SEC_MAX) ? gpm_pkg::FB_SEC_MAX
                                                             : reg_wdata[15:8];
  wire [7:0] w_rf = (reg_wdata[23:16] > gpm_pkg::FAIL_SEC_MAX) ? gpm_pkg::FAIL_SEC_MAX
                                                                : reg_wdata[23:16];
  wire [6:0] w_om = (reg_wdata[30:24] == 7'h00) ? 7'h01 :
                    (reg_wdata[30:24] > 7'h40)  ? 7'h40 : reg_wdata[30:24];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      nom_freq  <= gpm_pkg::NOM_FREQ_RST;
      flo_warn  <= gpm_pkg::FLO_WARN_RST;
      flo_sd    <= gpm_pkg::FLO_SD_RST;
      fhi_warn  <= gpm_pkg::FHI_WARN_RST;
      fhi_sd    <= gpm_pkg::FHI_SD_RST;
      blo_warn  <= gpm_pkg::BLO_WARN_RST;
      blo_sd    <= gpm_pkg::BLO_SD_RST;
      bhi_warn  <= gpm_pkg::BHI_WARN_RST;
      bhi_sd    <= gpm_pkg::BHI_SD_RST;
      freq_fail <= gpm_pkg::FREQ_FAIL_RST;
      batt_fail <= gpm_pkg::BATT_FAIL_RST;
      rpow_fail <= gpm_pkg::RPOW_FAIL_RST;
      oc_mult   <= gpm_pkg::OC_MULT_RST;
      vunb_pct  <= 8'h00;
      iunb_pct  <= 8'h00;
      vunb_act  <= 2'h0;
      iunb_act  <= 2'h0;
      oc_act    <= 1'b0;
      rpow_warn <= 16'h0000;
      rpow_ld   <= 16'h0000;
      oc_lim1   <= 16'h0000;
      oc_lim2   <= 16'h0000;
      oc_lim3   <= 16'h0000;
      mask      <= '0;
    end else begin
      if (wr_nom) begin
        nom_freq <= reg_wdata[15:0];
      end
      if (wr_flim) begin
        {fhi_sd, fhi_warn, flo_sd, flo_warn} <= reg_wdata;
      end
      if (wr_blo) begin
        {blo_sd, blo_warn} <= reg_wdata;
      end
      if (wr_bhi) begin
        {bhi_sd, bhi_warn} <= reg_wdata;
      end
      if (wr_tim) begin
        freq_fail <= w_ff;
        batt_fail <= w_bf;
        rpow_fail <= w_rf;
        oc_mult   <= w_om;
      end
      if (wr_unb) begin
        vunb_pct <= reg_wdata[7:0];
        iunb_pct <= reg_wdata[15:8];
        vunb_act <= reg_wdata[17:16];
        iunb_act <= reg_wdata[19:18];
        oc_act   <= reg_wdata[20];
      end
      if (wr_rpow) begin
        {rpow_ld, rpow_warn} <= reg_wdata;
      end
      if (wr_oc12) begin
        {oc_lim2, oc_lim1} <= reg_wdata;
      end
      if (wr_oc3) begin
        oc_lim3 <= reg_wdata[15:0];
      end
      if (wr_mask) begin
        mask <= reg_wdata[gpm_pkg::N_STATUS-1:0];
      end
    end
  end

  // ==========================================================================
  // Time base
  // ==========================================================================
  logic [23:0] tick_cnt;
  wire         tick = (tick_cnt == 24'(TICK_CYC - 1));

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tick_cnt <= 24'h000000;
    end else begin
      tick_cnt <= tick ? 24'h000000 : tick_cnt + 24'h000001;
    end
  end

  // ==========================================================================
  // Frequency limits
  // ==========================================================================
  // percent of nominal
  function automatic logic [31:0] pct_of(input logic [15:0] nom, input logic [7:0] p,
                                         input logic up);
    logic [31:0] base;
    logic [31:0] delta;
    base  = 32'(nom) * 32'd100;
    delta = 32'(nom) * 32'(p);
    pct_of = up ? base + delta : (delta > base ? 32'h0 : base - delta);
  endfunction

  wire [31:0] f_scaled = 32'(gen_freq) * 32'd100;
  wire f_lo_w = feeding_load && f_scaled < pct_of(nom_freq, flo_warn, 1'b0);
  wire f_lo_s = feeding_load && f_scaled < pct_of(nom_freq, flo_sd, 1'b0);
  wire f_hi_w = feeding_load && f_scaled > pct_of(nom_freq, fhi_warn, 1'b1);
  wire f_hi_s = feeding_load && f_scaled > pct_of(nom_freq, fhi_sd, 1'b1);

  // ==========================================================================
  // Battery limits
  // ==========================================================================
  // low and high battery
  wire b_lo_w = batt_volt < blo_warn;
  wire b_lo_s = batt_volt < blo_sd;
  wire b_hi_w = batt_volt > bhi_warn;
  wire b_hi_s = batt_volt > bhi_sd;

  // ==========================================================================
  // Unbalance: |3*x - sum| * 100 > pct * sum
  // ==========================================================================
  function automatic logic unbal(input logic [15:0] a, input logic [15:0] b,
                                 input logic [15:0] c, input logic [7:0] p);
    logic [17:0] sum;
    logic [17:0] t;
    logic [17:0] d;
    logic [31:0] lim;
    sum   = 18'(a) + 18'(b) + 18'(c);
    lim   = 32'(sum) * 32'(p);
    unbal = 1'b0;
    for (int k = 0; k < 3; k++) begin
      t = 18'(k == 0 ? a : k == 1 ? b : c) * 18'd3;
      d = (t > sum) ? t - sum : sum - t;
      if (32'(d) * 32'd100 > lim) begin
        unbal = 1'b1;
      end
    end
  endfunction

  wire v_unb = (vunb_pct != 8'h00) && unbal(phase_v1, phase_v2, phase_v3, vunb_pct);
  wire i_unb = (iunb_pct != 8'h00) && unbal(phase_i1, phase_i2, phase_i3, iunb_pct);

  // ==========================================================================
  // Reverse power and overcurrent
  // ==========================================================================
  wire        p_neg = active_power[16];
  wire [16:0] p_mag = 17'(~active_power + 17'h00001);
  wire r_w = (rpow_warn != 16'h0000) && p_neg && p_mag > 17'(rpow_warn);
  wire r_l = (rpow_warn != 16'h0000) && p_neg && p_mag > 17'(rpow_ld);

  wire [15:0] oc_lim = (limit_set == gpm_pkg::GPM_SET_SEC) ? oc_lim2 :
                       (limit_set == gpm_pkg::GPM_SET_TER) ? oc_lim3 : oc_lim1;
  wire oc_v = feeding_load && oc_lim != 16'h0000 &&
              (phase_i1 > oc_lim || phase_i2 > oc_lim || phase_i3 > oc_lim);

  // ==========================================================================
  // Fail timers
  // ==========================================================================
  localparam int NT = 12;
  wire [NT-1:0] viol  = {oc_v, r_l, r_w, i_unb, v_unb,
                         b_hi_s, b_hi_w, b_lo_s, b_lo_w, f_hi_s, f_hi_w, f_lo_s};
  wire [NT-1:0] flo_f;
  wire          flo_w_fault;
  wire [11:0]   fsec = 12'(freq_fail) * 12'(gpm_pkg::TICKS_PER_SEC);
  wire [11:0]   bsec = 12'(batt_fail) * 12'(gpm_pkg::TICKS_PER_SEC);
  wire [11:0]   rsec = 12'(rpow_fail) * 12'(gpm_pkg::TICKS_PER_SEC);
  wire [11:0]   osec = 12'((gpm_pkg::OC_BASE_TICKS * 64) / (int'(oc_mult) * 16));
  wire [11:0]   lim_tab [NT];

  // frequency timer, battery timer, zero for unbalance, reverse power timer, overcurrent timer
  assign lim_tab[0]  = fsec;
  assign lim_tab[1]  = fsec;
  assign lim_tab[2]  = fsec;
  assign lim_tab[3]  = bsec;
  assign lim_tab[4]  = bsec;
  assign lim_tab[5]  = bsec;
  assign lim_tab[6]  = bsec;
  assign lim_tab[7]  = 12'h000;
  assign lim_tab[8]  = 12'h000;
  assign lim_tab[9]  = rsec;
  assign lim_tab[10] = rsec;
  assign lim_tab[11] = osec;

  gpm_fail_timer #(.W(12)) u_flo_w (
    .clk   (clk),
    .reset (reset),
    .tick  (tick),
    .viol  (f_lo_w),
    .limit (fsec),
    .fault (flo_w_fault)
  );

  genvar g;
  generate
    for (g = 0; g < NT; g++) begin : g_tmr
      gpm_fail_timer #(.W(12)) u_t (
        .clk   (clk),
        .reset (reset),
        .tick  (tick),
        .viol  (viol[g]),
        .limit (lim_tab[g]),
        .fault (flo_f[g])
      );
    end
  endgenerate

  // ==========================================================================
  // Events, sticky status, outputs
  // ==========================================================================
  logic [gpm_pkg::N_STATUS-1:0] ev;
  always_comb begin
    ev = '0;
    ev[gpm_pkg::B_FREQ_LO_WARN] = flo_w_fault;
    ev[gpm_pkg::B_FREQ_LO_SD]   = flo_f[0];
    ev[gpm_pkg::B_FREQ_HI_WARN] = flo_f[1];
    ev[gpm_pkg::B_FREQ_HI_SD]   = flo_f[2];
    ev[gpm_pkg::B_BATT_LO_WARN] = flo_f[3];
    ev[gpm_pkg::B_BATT_LO_SD]   = flo_f[4];
    ev[gpm_pkg::B_BATT_HI_WARN] = flo_f[5];
    ev[gpm_pkg::B_BATT_HI_SD]   = flo_f[6];
    ev[gpm_pkg::B_VUNB_SD]   = flo_f[7] && vunb_act == gpm_pkg::GPM_ACT_SD;
    ev[gpm_pkg::B_VUNB_LD]   = flo_f[7] && vunb_act == gpm_pkg::GPM_ACT_LD;
    ev[gpm_pkg::B_VUNB_WARN] = flo_f[7] && vunb_act == gpm_pkg::GPM_ACT_WARN;
    ev[gpm_pkg::B_IUNB_SD]   = flo_f[8] && iunb_act == gpm_pkg::GPM_ACT_SD;
    ev[gpm_pkg::B_IUNB_LD]   = flo_f[8] && iunb_act == gpm_pkg::GPM_ACT_LD;
    ev[gpm_pkg::B_IUNB_WARN] = flo_f[8] && iunb_act == gpm_pkg::GPM_ACT_WARN;
    ev[gpm_pkg::B_RPOW_WARN] = flo_f[9];
    ev[gpm_pkg::B_RPOW_LD]   = flo_f[10];
    ev[gpm_pkg::B_OC_SD] = flo_f[11] && !oc_act;
    ev[gpm_pkg::B_OC_LD] = flo_f[11] && oc_act;
  end

  wire [gpm_pkg::N_STATUS-1:0] clr = wr_stat ? reg_wdata[gpm_pkg::N_STATUS-1:0] : '0;
  wire [gpm_pkg::N_STATUS-1:0] next_status = (status & ~clr) | ev;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  assign shutdown    = |(status & gpm_pkg::SD_BITS);
  assign load_dump   = |(status & gpm_pkg::LD_BITS);
  assign warning     = |(status & ~(gpm_pkg::SD_BITS | gpm_pkg::LD_BITS));
  assign engine_stop = shutdown;
  assign irq         = |(status & mask);

  // ==========================================================================
  // Read port
  // ==========================================================================
  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr)
      gpm_pkg::A_NOM_FREQ: rd_mux = {16'h0000, nom_freq};
      gpm_pkg::A_FREQ_LIM: rd_mux = {fhi_sd, fhi_warn, flo_sd, flo_warn};
      gpm_pkg::A_BATT_LO:  rd_mux = {blo_sd, blo_warn};
      gpm_pkg::A_BATT_HI:  rd_mux = {bhi_sd, bhi_warn};
      gpm_pkg::A_TIMERS:   rd_mux = {1'b0, oc_mult, rpow_fail, batt_fail, freq_fail};
      gpm_pkg::A_UNBAL:    rd_mux = {11'h000, oc_act, iunb_act, vunb_act,
                                     iunb_pct, vunb_pct};
      gpm_pkg::A_RPOW:     rd_mux = {rpow_ld, rpow_warn};
      gpm_pkg::A_OC_LIM12: rd_mux = {oc_lim2, oc_lim1};
      gpm_pkg::A_OC_LIM3:  rd_mux = {16'h0000, oc_lim3};
      gpm_pkg::A_STATUS:   rd_mux = 32'(status);
      gpm_pkg::A_MASK:     rd_mux = 32'(mask);
      gpm_pkg::A_FAULTS:   rd_mux = {20'h00000, flo_f};
      default:             rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= reg_read ? rd_mux : 32'h00000000;
    end
  end

endmodule

// ---- gpm_monitor_checker.sv ----
// Concurrent checks on the ports of the genset protection monitor.
// Assumes it is bound onto gpm_monitor and sees only its ports.
module gpm_monitor_checker #(
  parameter int unsigned TICK_CYC = 10
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        feeding_load,
  input wire logic [15:0] gen_freq,
  input wire logic [15:0] batt_volt,
  input wire logic [15:0] phase_v1,
  input wire logic [15:0] phase_v2,
  input wire logic [15:0] phase_v3,
  input wire logic [15:0] phase_i1,
  input wire logic [15:0] phase_i2,
  input wire logic [15:0] phase_i3,
  input wire logic [16:0] active_power,
  input wire logic [1:0]  limit_set,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic        warning,
  input wire logic        load_dump,
  input wire logic        shutdown,
  input wire logic        engine_stop,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // ==========================================================================
  // Sequences
  // ==========================================================================
  sequence kept(f);
    f && !(reg_write && reg_addr == gpm_pkg::A_STATUS);
  endsequence
  sequence unmapped_read;
    reg_read && reg_addr > 8'h2C;
  endsequence
  // ==========================================================================
  // Assertions
  // ==========================================================================
  stop_follows_sd_a: assert property (engine_stop == shutdown)
    else $error("engine stop differs from shutdown");
  warn_sticky_a: assert property (kept(warning) |=> warning)
    else $error("warning dropped without a status clear");
  ld_sticky_a: assert property (kept(load_dump) |=> load_dump)
    else $error("load dump dropped without a status clear");
  sd_sticky_a: assert property (kept(shutdown) |=> shutdown)
    else $error("shutdown dropped without a status clear");
  irq_sticky_a: assert property (irq && !reg_write |=> irq)
    else $error("interrupt dropped without a register write");
  reset_quiet_a: assert property (disable iff (1'b0) reset |->
    !warning && !load_dump && !shutdown && !irq) else $error("alarm output high in reset");
  rdata_pulse_a: assert property (!reg_read |=> reg_rdata == 32'h0)
    else $error("read data outside the read answer cycle");
  unmapped_zero_a: assert property (unmapped_read |=> reg_rdata == 32'h0)
    else $error("unmapped read returned nonzero");
endmodule

bind gpm_monitor gpm_monitor_checker #(.TICK_CYC(TICK_CYC)) chk_u (.*);

// ---- gpm_monitor_tb_top.sv ----
// Self-checking bench for the genset protection monitor.
// Assumes a short tick (10 cycles) so fail timers run in hundreds of cycles.
module gpm_monitor_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, reset, feeding_load, reg_write, reg_read;
  logic        warning, load_dump, shutdown, engine_stop, irq;
  logic [15:0] gen_freq, batt_volt, phase_v1, phase_v2, phase_v3;
  logic [15:0] phase_i1, phase_i2, phase_i3;
  logic [16:0] active_power;
  logic [1:0]  limit_set;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  int          n_errors = 0, samples_checked = 0, cycles = 0;
  gpm_monitor #(.TICK_CYC(10)) dut_u (.*);
  gpm_front_end fe_u (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_errors++;
      $display("BAD %0t timeout", $time);
      close_out();
    end
  end
  // ==========================================================================
  // Register access and checks
  // ==========================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    {reg_addr, reg_read} <= {a, 1'b1};
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic restore();
    fe_u.nominal();
    wr(gpm_pkg::A_STATUS, 32'h0003FFFF);
    rd(gpm_pkg::A_STATUS, 32'h0);
    fe_u.put(5, 17'h00001);
  endtask
  task automatic step(input int i, input logic [16:0] v, input logic fl, input logic [31:0] e);
    fe_u.put(5, {16'h0, fl});
    fe_u.put(i, v);
    repeat (80) @(posedge clk);
    rd(gpm_pkg::A_STATUS, 32'h0);
    repeat (470) @(posedge clk);
    rd(gpm_pkg::A_STATUS, e);
    chk({27'h0, irq, warning, load_dump, shutdown, engine_stop},
        {27'h0, e[0], |(e & 32'h6455), |(e & 32'h29200), {2{|(e & 32'h109AA)}}});
    restore();
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    {reset, reg_write, reg_read, reg_addr, reg_wdata, limit_set} = {3'b100, 42'h0};
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rd(8'h00, 32'h00000032);
    rd(8'h04, 32'h140F140F);
    rd(8'h08, 32'h005A0078);
    rd(8'h0C, 32'h012C0122);
    rd(8'h10, 32'h10050301);
    rd(8'h30, 32'h0);
    wr(gpm_pkg::A_MASK, 32'h00000001);
    step(0, 17'h0002A, 1'b1, 32'h1);
    step(0, 17'h00027, 1'b1, 32'h3);
    step(0, 17'h0003B, 1'b1, 32'h4);
    step(0, 17'h0003D, 1'b1, 32'hC);
    step(0, 17'h00027, 1'b0, 32'h0);
    fe_u.put(0, 17'h0002A);
    repeat (75) @(posedge clk);
    fe_u.put(0, 17'h00032);
    repeat (5) @(posedge clk);
    fe_u.put(0, 17'h0002A);
    repeat (75) @(posedge clk);
    rd(gpm_pkg::A_STATUS, 32'h0);
    restore();
    step(1, 17'h00073, 1'b1, 32'h10);
    step(1, 17'h00055, 1'b1, 32'h30);
    step(1, 17'h00127, 1'b1, 32'h40);
    step(1, 17'h00131, 1'b1, 32'hC0);
    step(4, -17'sd250, 1'b1, 32'h0);
    wr(gpm_pkg::A_RPOW, 32'h00C80064);
    step(4, -17'sd150, 1'b1, 32'h4000);
    step(4, -17'sd250, 1'b1, 32'hC000);
    step(3, 17'h0015E, 1'b1, 32'h0);
    wr(gpm_pkg::A_OC_LIM12, 32'h012C00C8);
    wr(gpm_pkg::A_OC_LIM3, 32'h00000190);
    step(3, 17'h0015E, 1'b1, 32'h10000);
    step(3, 17'h0015E, 1'b0, 32'h0);
    @(posedge clk) limit_set <= 2'h1;
    step(3, 17'h0015E, 1'b1, 32'h10000);
    @(posedge clk) limit_set <= 2'h2;
    step(3, 17'h0015E, 1'b1, 32'h0);
    @(posedge clk) limit_set <= 2'h0;
    wr(gpm_pkg::A_UNBAL, 32'h00100000);
    step(3, 17'h0015E, 1'b1, 32'h20000);
    for (int a = 0; a < 5; a++) begin
      wr(gpm_pkg::A_UNBAL, a == 0 ? 32'h00050000 : 32'h0A0A | ((a - 1) * 32'h00050000));
      fe_u.put(2, 17'h0012C);
      fe_u.put(3, 17'h00096);
      repeat (3) @(posedge clk);
      rd(gpm_pkg::A_STATUS, a < 2 ? 32'h0 : 32'h900 << (a - 2));
      chk({29'h0, warning, load_dump, shutdown}, {29'h0, a == 4, a == 3, a == 2});
      rd(gpm_pkg::A_FAULTS, a == 0 ? 32'h0 : 32'h180);
      restore();
    end
    wr(gpm_pkg::A_TIMERS, 32'h7FFF0B0B);
    rd(gpm_pkg::A_TIMERS, 32'h40780A0A);
    close_out();
  end
endmodule

// ---- gpm_pkg.sv ----
// Constants for the genset protection monitor.
// Assumes a 100 MHz system clock and a register port with one-cycle read latency.
package gpm_pkg;

  // ==========================================================================
  // Clock and time base
  // ==========================================================================
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned TICK_MS        = 100;
  localparam int unsigned TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TICKS_PER_SEC  = 1000 / TICK_MS;

  // ==========================================================================
  // Register offsets (byte addresses)
  // ==========================================================================
  localparam logic [7:0] A_NOM_FREQ   = 8'h00;
  localparam logic [7:0] A_FREQ_LIM   = 8'h04;
  localparam logic [7:0] A_BATT_LO    = 8'h08;
  localparam logic [7:0] A_BATT_HI    = 8'h0C;
  localparam logic [7:0] A_TIMERS     = 8'h10;
  localparam logic [7:0] A_UNBAL      = 8'h14;
  localparam logic [7:0] A_RPOW       = 8'h18;
  localparam logic [7:0] A_OC_LIM12   = 8'h1C;
  localparam logic [7:0] A_OC_LIM3    = 8'h20;
  localparam logic [7:0] A_STATUS     = 8'h24;
  localparam logic [7:0] A_MASK       = 8'h28;
  localparam logic [7:0] A_FAULTS     = 8'h2C;

  // ==========================================================================
  // Status bit positions
  // ==========================================================================
  localparam int B_FREQ_LO_WARN = 0;
  localparam int B_FREQ_LO_SD   = 1;
  localparam int B_FREQ_HI_WARN = 2;
  localparam int B_FREQ_HI_SD   = 3;
  localparam int B_BATT_LO_WARN = 4;
  localparam int B_BATT_LO_SD   = 5;
  localparam int B_BATT_HI_WARN = 6;
  localparam int B_BATT_HI_SD   = 7;
  localparam int B_VUNB_SD      = 8;
  localparam int B_VUNB_LD      = 9;
  localparam int B_VUNB_WARN    = 10;
  localparam int B_IUNB_SD      = 11;
  localparam int B_IUNB_LD      = 12;
  localparam int B_IUNB_WARN    = 13;
  localparam int B_RPOW_WARN    = 14;
  localparam int B_RPOW_LD      = 15;
  localparam int B_OC_SD        = 16;
  localparam int B_OC_LD        = 17;
  localparam int N_STATUS       = 18;
  localparam logic [N_STATUS-1:0] SD_BITS = 18'h109AA;
  localparam logic [N_STATUS-1:0] LD_BITS = 18'h29200;

  // ==========================================================================
  // Reset values of settings
  // ==========================================================================
  localparam logic [15:0] NOM_FREQ_RST   = 16'h0032;  // 50 Hz
  localparam logic [7:0]  FLO_WARN_RST   = 8'h0F;     // -15 %
  localparam logic [7:0]  FLO_SD_RST     = 8'h14;     // -20 %
  localparam logic [7:0]  FHI_WARN_RST   = 8'h0F;     // +15 %
  localparam logic [7:0]  FHI_SD_RST     = 8'h14;     // +20 %
  localparam logic [15:0] BLO_WARN_RST   = 16'h0078;  // 12.0 V in 0.1 V
  localparam logic [15:0] BLO_SD_RST     = 16'h005A;  // 9.0 V
  localparam logic [15:0] BHI_WARN_RST   = 16'h0122;  // 29.0 V
  localparam logic [15:0] BHI_SD_RST     = 16'h012C;  // 30.0 V
  localparam logic [7:0]  FREQ_FAIL_RST  = 8'h01;     // s
  localparam logic [7:0]  BATT_FAIL_RST  = 8'h03;     // s
  localparam logic [7:0]  RPOW_FAIL_RST  = 8'h05;     // s
  localparam logic [6:0]  OC_MULT_RST    = 7'h10;     // 16
  localparam logic [7:0]  FAIL_SEC_MAX   = 8'h78;     // 120 s ceiling
  localparam logic [7:0]  FB_SEC_MAX     = 8'h0A;     // 10 s ceiling

  // ==========================================================================
  // Unbalance actions, overcurrent limit sets and overcurrent reaction time
  // ==========================================================================
  typedef enum logic [1:0] {
    GPM_ACT_NONE = 2'b00,
    GPM_ACT_SD   = 2'b01,
    GPM_ACT_LD   = 2'b10,
    GPM_ACT_WARN = 2'b11
  } gpm_act_e;

  typedef enum logic [1:0] {
    GPM_SET_PRI = 2'b00,
    GPM_SET_SEC = 2'b01,
    GPM_SET_TER = 2'b10
  } gpm_set_e;

  localparam int unsigned OC_BASE_TICKS = 64;  // reaction at multiplier 4

endpackage
